//--- logic/fhc_regs.svh
// register offsets, field positions, reset values and timing counts of the flash host controller
`ifndef FHC_REGS_SVH
`define FHC_REGS_SVH
// word indices on the avalon slave
`define FHC_CTRL_IDX     3'h0
`define FHC_ADDR_IDX     3'h1
`define FHC_WDATA_IDX    3'h2
`define FHC_CMD_IDX      3'h3
`define FHC_STATUS_IDX   3'h4
`define FHC_RDATA_IDX    3'h5
// control fields
`define FHC_CTRL_BYTE    0
`define FHC_CTRL_WP      1
`define FHC_CTRL_ACCEL   2
`define FHC_CTRL_RST     3'h0
// command fields
`define FHC_CMD_READ     0
`define FHC_CMD_WRITE    1
`define FHC_CMD_POLL     2
`define FHC_CMD_HWRST    3
// status fields
`define FHC_ST_BUSY      0
`define FHC_ST_DONE      1
`define FHC_ST_READY     2
`define FHC_ST_TMO       3
`define FHC_ST_DROP      4
// toggle bit watched while polling
`define FHC_TOGGLE_BIT   6
// timing in ns and derived cycle counts
`define FHC_CLK_NS       100
`define FHC_T_ACC_NS     90
`define FHC_T_WP_NS      35
`define FHC_T_RP_NS      500
`define FHC_T_RH_NS      200
`define FHC_ACC_CYC      ((`FHC_T_ACC_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_WP_CYC       ((`FHC_T_WP_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_RP_CYC       ((`FHC_T_RP_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_RH_CYC       ((`FHC_T_RH_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_POLL_MAX     4096
`endif

//--- logic/fhc_pkg.sv
// types shared by the flash host controller modules
package fhc_pkg;
   // one flash bus cycle request
   typedef struct packed {
      logic        is_write;
      logic        byte_mode;
      logic [21:0] addr;
      logic [15:0] wdata;
   } fhc_req_s;
   // flash strobes, all active low
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
   } fhc_strobe_s;
   // main sequencer states
   typedef enum logic [5:0] {
      M_IDLE   = 6'h01,
      M_READ   = 6'h02,
      M_WRITE  = 6'h04,
      M_POLL_A = 6'h08,
      M_POLL_B = 6'h10,
      M_RST    = 6'h20
   } fhc_main_e;
   // single cycle sequencer states
   typedef enum logic [3:0] {
      C_IDLE   = 4'h1,
      C_SETUP  = 4'h2,
      C_STROBE = 4'h4,
      C_HOLD   = 4'h8
   } fhc_cyc_e;
endpackage

//--- logic/fhc_cycle.sv
// one read or write cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "fhc_regs.svh"
module fhc_cycle
   import fhc_pkg::*;
#(
   parameter int ACC_CYC = `FHC_ACC_CYC,
   parameter int WP_CYC  = `FHC_WP_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // request from the sequencer
   input  wire logic        start,
   input  wire fhc_req_s    req,
   output logic             done,
   output logic [15:0]      rdata,
   // flash pins
   output logic [20:0]      flash_addr,
   output fhc_strobe_s      strobe,
   output logic             byte_n,
   output logic [15:0]      dq_out,
   output logic [15:0]      dq_oe,
   input  wire logic [15:0] dq_in
);
   fhc_cyc_e   st_reg;
   logic [7:0] cnt_reg;
   fhc_req_s   req_reg;

   // state and counter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg  <= C_IDLE;
         cnt_reg <= 8'h00;
         req_reg <= '0;
      end else begin
         case (st_reg)
            C_IDLE: begin
               if (start) begin
                  req_reg <= req;
                  st_reg  <= C_SETUP;
               end
            end
            C_SETUP: begin
               cnt_reg <= req_reg.is_write ? 8'(WP_CYC) : 8'(ACC_CYC);
               st_reg  <= C_STROBE;
            end
            C_STROBE: begin
               cnt_reg <= cnt_reg - 8'h01;
               if (cnt_reg == 8'h01) begin
                  st_reg <= C_HOLD;
               end
            end
            C_HOLD: begin
               st_reg <= C_IDLE;
            end
            default: begin
               st_reg <= C_IDLE;
            end
         endcase
      end
   end

   // pin drive; idle leaves the chip deselected
   // R20: idle standby
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         strobe     <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
         flash_addr <= 21'h000000;
         byte_n     <= 1'b1;
         dq_out     <= 16'h0000;
         dq_oe      <= 16'h0000;
      end else begin
         case (st_reg)
            C_SETUP: begin
               // R1: word or byte addressing
               byte_n     <= !req_reg.byte_mode;
               flash_addr <= req_reg.byte_mode ? req_reg.addr[21:1] : req_reg.addr[20:0];
               strobe.ce_n <= 1'b0;
               strobe.oe_n <= req_reg.is_write;
               strobe.we_n <= !req_reg.is_write;
               // R2: byte lane usage
               if (req_reg.byte_mode) begin
                  dq_out <= {req_reg.addr[0], 7'h00, req_reg.wdata[7:0]};
                  dq_oe  <= {1'b1, 7'h00, {8{req_reg.is_write}}};
               end else begin
                  dq_out <= req_reg.wdata;
                  dq_oe  <= {16{req_reg.is_write}};
               end
            end
            C_STROBE: begin
               if (cnt_reg == 8'h01) begin
                  strobe.oe_n <= 1'b1;
                  strobe.we_n <= 1'b1;
               end
            end
            C_HOLD: begin
               // R3: release data one cycle after strobes
               strobe.ce_n <= 1'b1;
               dq_oe       <= 16'h0000;
            end
            default: begin
               strobe.ce_n <= 1'b1;
               strobe.oe_n <= 1'b1;
               strobe.we_n <= 1'b1;
            end
         endcase
      end
   end

   // capture read data at the end of the strobe
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= 16'h0000;
         done  <= 1'b0;
      end else begin
         done <= (st_reg == C_HOLD);
         if (st_reg == C_STROBE && cnt_reg == 8'h01 && !req_reg.is_write) begin
            rdata <= req_reg.byte_mode ? {8'h00, dq_in[7:0]} : dq_in;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // R3: no write and read strobe together
   strobe_excl_a: assert property (!(!strobe.we_n && !strobe.oe_n)) // R3
      else $error("write and output strobes low together");
   // R3: never drive data while the flash outputs
   no_contend_a: assert property (|dq_oe[14:0] |-> strobe.oe_n) // R3
      else $error("data driven while output enable low");
   // R2: lanes 14 to 8 stay undriven in byte mode, lane 15 carries the low address bit
   byte_lanes_a: assert property (!byte_n |-> dq_oe[14:8] == 7'h00) // R2
      else $error("upper lanes driven in byte mode");
   sequence cyc_begin_s;
      st_reg == C_IDLE && start;
   endsequence
   sequence cyc_end_s;
      ##[3:260] done;
   endsequence
   // R3: every cycle finishes with a done pulse
   cyc_done_a: assert property (cyc_begin_s |-> cyc_end_s) // R3
      else $error("flash cycle did not finish");
endmodule
`default_nettype wire

//--- logic/fhc_top.sv
// flash host controller: avalon register slave driving a dual bank flash
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "fhc_regs.svh"
// Summary of operation
// R1: word or byte units by organisation
// R2: sixteen lanes words, low eight bytes
// R3: host sequences strobes, avoids bus contention
// R4: other bank reads during busy bank
// R5: indicator bit read via software reads
// R6: secured sector handled by software commands
// R7: commands are plain writes to flash
// R8: busy shown by pin and toggle bits
// R9: flash returns to array reads itself
// R10: reset pin aborts flash command state
// R11: protect pin guards outer boot sectors
// R12: accelerate pin speeds up programming
// R13: protected sectors refuse program, erase
// R14: temporary unprotect allows in-system change
// R15: erase suspend and resume by commands
// R16: erase chosen sectors, others untouched
// R17: unlock bypass shortens program sequences
// R18: flash ignores writes at low supply
// R19: idle address brings automatic sleep
// R20: host deselects chip for standby
// R21: wait for completion before reading bank
module fhc_top
   import fhc_pkg::*;
#(
   parameter int ACC_CYC  = `FHC_ACC_CYC,
   parameter int WP_CYC   = `FHC_WP_CYC,
   parameter int RP_CYC   = `FHC_RP_CYC,
   parameter int RH_CYC   = `FHC_RH_CYC,
   parameter int POLL_MAX = `FHC_POLL_MAX
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // avalon-mm slave
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // flash address and strobes
   output logic [20:0]      flash_addr,
   output logic             flash_ce_n,
   output logic             flash_oe_n,
   output logic             flash_we_n,
   output logic             flash_byte_n,
   output logic             flash_reset_n,
   // flash data lanes
   output logic [15:0]      flash_dq_out,
   output logic [15:0]      flash_dq_oe,
   input  wire logic [15:0] flash_dq_in,
   // flash status and protection pins
   input  wire logic        ready_busy_out_n,
   output logic             protect_accel_pin,
   output logic             program_speedup
);
   fhc_main_e   st_reg;
   logic        ack_reg;
   logic        byte_mode_reg;
   logic [21:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg;
   logic [15:0] first_rd_reg;
   logic        done_reg;
   logic        tmo_reg;
   logic        drop_reg;
   logic        ready_reg;
   logic [15:0] wait_cnt_reg;
   logic [12:0] poll_cnt_reg;
   logic        cyc_start_reg;
   logic        cyc_done;
   logic [15:0] cyc_rdata;
   fhc_strobe_s cyc_strobe;
   fhc_req_s    cyc_req;
   logic        wr_take;
   logic        cmd_take;
   logic        busy;
   logic        toggled;
   logic        ev_done;
   logic        ev_tmo;
   logic        ev_drop;

   // true for a register write taking effect at this edge
   function automatic logic reg_wr(input logic [2:0] idx);
      reg_wr = avs_write && ack_reg && (avs_address == idx);
   endfunction

   assign wr_take  = avs_write && ack_reg;
   assign cmd_take = reg_wr(`FHC_CMD_IDX) && (|avs_writedata[3:0]);
   assign busy     = (st_reg != M_IDLE);
   assign toggled  = first_rd_reg[`FHC_TOGGLE_BIT] != cyc_rdata[`FHC_TOGGLE_BIT];
   assign cyc_req  = '{is_write: (st_reg == M_WRITE), byte_mode: byte_mode_reg,
                       addr: addr_reg, wdata: wdata_reg};

   // one wait cycle then a single-cycle answer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_reg         <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         ack_reg         <= (avs_read || avs_write) && !ack_reg;
         avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
      end
   end

   // read data mux, unmapped words read zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack_reg) begin
         if (avs_address == `FHC_CTRL_IDX) begin
            avs_readdata <= {29'h0, program_speedup, !protect_accel_pin, byte_mode_reg};
         end else if (avs_address == `FHC_ADDR_IDX) begin
            avs_readdata <= {10'h000, addr_reg};
         end else if (avs_address == `FHC_WDATA_IDX) begin
            avs_readdata <= {16'h0000, wdata_reg};
         end else if (avs_address == `FHC_STATUS_IDX) begin
            avs_readdata <= {27'h0, drop_reg, tmo_reg, ready_reg, done_reg, busy};
         end else if (avs_address == `FHC_RDATA_IDX) begin
            avs_readdata <= {16'h0000, rdata_reg};
         end else begin
            avs_readdata <= 32'h00000000;
         end
      end
   end

   // configuration and operand registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         byte_mode_reg     <= 1'b0;
         protect_accel_pin <= 1'b1;
         program_speedup   <= 1'b0;
         addr_reg          <= 22'h000000;
         wdata_reg         <= 16'h0000;
      end else if (wr_take) begin
         if (avs_address == `FHC_CTRL_IDX) begin
            byte_mode_reg     <= avs_writedata[`FHC_CTRL_BYTE];
            // R11: low level protects outer boot sectors
            protect_accel_pin <= !avs_writedata[`FHC_CTRL_WP];
            // R12: accelerate request to supply switch
            program_speedup   <= avs_writedata[`FHC_CTRL_ACCEL];
         end else if (avs_address == `FHC_ADDR_IDX && !busy) begin
            addr_reg <= avs_writedata[21:0];
         end else if (avs_address == `FHC_WDATA_IDX && !busy) begin
            wdata_reg <= avs_writedata[15:0];
         end
      end
   end

   // main sequencer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg        <= M_IDLE;
         cyc_start_reg <= 1'b0;
         flash_reset_n <= 1'b1;
         wait_cnt_reg  <= 16'h0000;
         poll_cnt_reg  <= 13'h0000;
         first_rd_reg  <= 16'h0000;
         rdata_reg     <= 16'h0000;
      end else begin
         cyc_start_reg <= 1'b0;
         case (st_reg)
            M_IDLE: begin
               if (cmd_take) begin
                  poll_cnt_reg <= 13'h0000;
                  if (avs_writedata[`FHC_CMD_HWRST]) begin
                     // R10: pulse the flash reset pin
                     flash_reset_n <= 1'b0;
                     wait_cnt_reg  <= 16'(RP_CYC + RH_CYC);
                     st_reg        <= M_RST;
                  end else if (avs_writedata[`FHC_CMD_READ]) begin
                     cyc_start_reg <= 1'b1;
                     st_reg        <= M_READ;
                  end else if (avs_writedata[`FHC_CMD_WRITE]) begin
                     // R7: command is an ordinary bus write
                     cyc_start_reg <= 1'b1;
                     st_reg        <= M_WRITE;
                  end else begin
                     cyc_start_reg <= 1'b1;
                     st_reg        <= M_POLL_A;
                  end
               end
            end
            M_READ: begin
               if (cyc_done) begin
                  rdata_reg <= cyc_rdata;
                  st_reg    <= M_IDLE;
               end
            end
            M_WRITE: begin
               if (cyc_done) begin
                  st_reg <= M_IDLE;
               end
            end
            M_POLL_A: begin
               if (cyc_done) begin
                  first_rd_reg  <= cyc_rdata;
                  cyc_start_reg <= 1'b1;
                  st_reg        <= M_POLL_B;
               end
            end
            M_POLL_B: begin
               if (cyc_done) begin
                  rdata_reg    <= cyc_rdata;
                  poll_cnt_reg <= poll_cnt_reg + 13'h0001;
                  // R21: done once toggle bit settles
                  if (!toggled || poll_cnt_reg == 13'(POLL_MAX - 1)) begin
                     st_reg <= M_IDLE;
                  end else begin
                     cyc_start_reg <= 1'b1;
                     st_reg        <= M_POLL_A;
                  end
               end
            end
            M_RST: begin
               wait_cnt_reg <= wait_cnt_reg - 16'h0001;
               if (wait_cnt_reg == 16'(RH_CYC + 1)) begin
                  flash_reset_n <= 1'b1;
               end
               if (wait_cnt_reg == 16'h0001) begin
                  st_reg <= M_IDLE;
               end
            end
            default: begin
               st_reg <= M_IDLE;
            end
         endcase
      end
   end

   // sticky status events
   assign ev_done = ((st_reg == M_READ || st_reg == M_WRITE) && cyc_done)
                 || (st_reg == M_POLL_B && cyc_done && !toggled)
                 || (st_reg == M_RST && wait_cnt_reg == 16'h0001);
   assign ev_tmo  = st_reg == M_POLL_B && cyc_done && toggled
                 && poll_cnt_reg == 13'(POLL_MAX - 1);
   assign ev_drop = reg_wr(`FHC_CMD_IDX) && busy;

   // done, timeout and drop flags, write one to clear, a new event wins; ready follows the pin
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         done_reg  <= 1'b0;
         tmo_reg   <= 1'b0;
         drop_reg  <= 1'b0;
         ready_reg <= 1'b0;
      end else begin
         // R8: ready pin shown in status
         ready_reg <= ready_busy_out_n;
         if (ev_done) begin
            done_reg <= 1'b1;
         end else if (reg_wr(`FHC_STATUS_IDX) && avs_writedata[`FHC_ST_DONE]) begin
            done_reg <= 1'b0;
         end
         if (ev_tmo) begin
            tmo_reg <= 1'b1;
         end else if (reg_wr(`FHC_STATUS_IDX) && avs_writedata[`FHC_ST_TMO]) begin
            tmo_reg <= 1'b0;
         end
         if (ev_drop) begin
            drop_reg <= 1'b1;
         end else if (reg_wr(`FHC_STATUS_IDX) && avs_writedata[`FHC_ST_DROP]) begin
            drop_reg <= 1'b0;
         end
      end
   end

   // flash pin cycle engine
   fhc_cycle #(
      .ACC_CYC (ACC_CYC),
      .WP_CYC  (WP_CYC)
   ) u_cycle (
      .clk        (clk),
      .resetn     (resetn),
      .start      (cyc_start_reg),
      .req        (cyc_req),
      .done       (cyc_done),
      .rdata      (cyc_rdata),
      .flash_addr (flash_addr),
      .strobe     (cyc_strobe),
      .byte_n     (flash_byte_n),
      .dq_out     (flash_dq_out),
      .dq_oe      (flash_dq_oe),
      .dq_in      (flash_dq_in)
   );

   assign flash_ce_n = cyc_strobe.ce_n;
   assign flash_oe_n = cyc_strobe.oe_n;
   assign flash_we_n = cyc_strobe.we_n;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence bus_req_s;
      (avs_read || avs_write) && avs_waitrequest && !ack_reg;
   endsequence
   // avalon answer after one wait cycle
   bus_answer_a: assert property (bus_req_s |=> !avs_waitrequest)
      else $error("avalon answer not given after one wait cycle");
   // R11: protect pin follows control write
   protect_pin_a: assert property (reg_wr(`FHC_CTRL_IDX) |=>
         protect_accel_pin == !$past(avs_writedata[`FHC_CTRL_WP])) // R11
      else $error("protect pin did not follow control write");
   // R12: accelerate output follows control write
   accel_pin_a: assert property (reg_wr(`FHC_CTRL_IDX) |=>
         program_speedup == $past(avs_writedata[`FHC_CTRL_ACCEL])) // R12
      else $error("accelerate output did not follow control write");
   // R7: write command reaches the strobe pin
   cmd_write_a: assert property (st_reg == M_IDLE && cmd_take
         && avs_writedata[`FHC_CMD_WRITE] && !avs_writedata[`FHC_CMD_READ]
         && !avs_writedata[`FHC_CMD_HWRST] |-> ##[2:20] !flash_we_n) // R7
      else $error("write command produced no write strobe");
   sequence rst_low_s;
      $fell(flash_reset_n) ##1 !flash_reset_n;
   endsequence
   // R10: reset pin pulse lasts and ends
   reset_pulse_a: assert property ($fell(flash_reset_n) |-> rst_low_s ##[0:RP_CYC] flash_reset_n)
      else $error("flash reset pulse too short or never released");
   // R21: poll ends when toggle bit stands
   poll_stop_a: assert property (st_reg == M_POLL_B && cyc_done && !toggled
         |=> st_reg == M_IDLE && done_reg) // R21
      else $error("poll did not stop on settled toggle bit");
   // busy command writes are flagged
   drop_flag_a: assert property (ev_drop |=> drop_reg)
      else $error("dropped command not flagged");
   // set wins over a same-cycle clear
   done_wins_a: assert property (ev_done |=> done_reg)
      else $error("completion event lost");
endmodule
`default_nettype wire

//--- verification/fhc_flash_model.sv
// behavioural dual bank flash answering the host controller
`timescale 1ns/1ps
`default_nettype none
module fhc_flash_model #(
   parameter int BUSY_CYC = 600
) (
   // timer clock and control pins
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [20:0] addr,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        byte_n,
   input  wire logic        prot_n,
   input  wire logic        speedup,
   // data lanes and status
   input  wire logic [15:0] dq_in,
   output logic [15:0]      dq,
   output logic             ready_n
);
   logic [15:0]     mem [32];
   logic [15:0]     last_q, pdata, drv;
   logic            pbank, armed, tog, we_q;
   int              busy_cnt;
   wire logic [4:0] idx = {addr[20], addr[3:0]};
   // array pattern and idle state
   initial begin
      for (int i = 0; i < 32; i++) mem[i] = 16'ha500 + 16'(i);
      {last_q, pdata, pbank, armed, tog, busy_cnt} = '0;
      we_q = 1'b1;
   end
   // status only in the busy bank
   always_comb begin
      drv = mem[idx];
      if (busy_cnt > 0 && addr[20] == pbank) drv = {8'h00, ~pdata[7], tog, 6'h00};
      if (!byte_n) drv = {~last_q[15:8], dq_in[15] ? drv[15:8] : drv[7:0]};
   end
   // drive array data while selected and enabled, else the inverted last read pattern
   assign dq = (!ce_n && !oe_n) ? drv : ~last_q;
   assign ready_n = (busy_cnt == 0);
   // toggle bit and released bus pattern
   always @(negedge oe_n) tog <= ~tog;
   always @(posedge clk) if (!ce_n && !oe_n) last_q <= drv;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         armed <= 1'b0;
         busy_cnt <= 0;
      end else begin
         we_q <= we_n;
         if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
         if (we_n && !we_q && !ce_n && busy_cnt == 0) begin
            armed <= !armed && dq_in[7:0] == 8'ha0;
            if (armed && (prot_n || addr[20:13] != 8'h00)) begin
               mem[idx] <= dq_in;
               pdata <= dq_in;
               pbank <= addr[20];
               busy_cnt <= speedup ? BUSY_CYC / 20 : BUSY_CYC;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/fhc_top_bench.sv
// self-checking bench of the flash host controller with a flash model
`timescale 1ns/1ps
`default_nettype none
`include "fhc_regs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
   $display("FAIL t=%0t got %h exp %h", $time, (a), (e)); end end
module fhc_top_bench
   import fhc_pkg::*;
;
   logic        clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [2:0]  adr = 3'h0;
   logic [31:0] wd = 32'h0, rdat, st, avs_rd;
   logic        wait_r, ce_n, oe_n, we_n, byte_n, rst_n, prot_n, spd, rdy_n;
   logic [20:0] f_addr;
   logic [15:0] dq_out, dq_oe, m_dq, dq_bus;
   int          fail_count = 0, num_checks = 0, cyc = 0;
   typedef struct {logic [2:0] c; logic [21:0] a; logic [15:0] e;} fhc_row_s;
   // control, address, expected read data
   fhc_row_s rows [6] = '{'{3'h0, 22'h000000, 16'ha500}, '{3'h0, 22'h10000f, 16'ha51f},
      '{3'h1, 22'h000006, 16'h0003}, '{3'h1, 22'h000007, 16'h00a5},
      '{3'h5, 22'h200008, 16'h0014}, '{3'h2, 22'h000002, 16'ha502}};
   // clock and hang limit
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   // bus resolution of both drivers
   assign dq_bus = (dq_oe & dq_out) | (~dq_oe & m_dq);
   fhc_top #(.POLL_MAX(8)) i_fhc_top (.clk(clk), .resetn(resetn), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(avs_rd),
      .avs_waitrequest(wait_r), .flash_addr(f_addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .flash_byte_n(byte_n), .flash_reset_n(rst_n),
      .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_bus),
      .ready_busy_out_n(rdy_n), .protect_accel_pin(prot_n), .program_speedup(spd));
   fhc_flash_model i_fhc_flash_model (.clk(clk), .reset_n(rst_n), .addr(f_addr),
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .byte_n(byte_n), .prot_n(prot_n),
      .speedup(spd), .dq_in(dq_bus), .dq(m_dq), .ready_n(rdy_n));
   // one avalon transfer held until waitrequest is sampled low
   task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      do begin
         @(posedge clk);
      end while (wait_r !== 1'b0);
      rdat = avs_rd;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   // command at an address, wait for idle, fetch status and data
   task automatic op(input logic [21:0] a, input logic [31:0] c);
      int n;
      n = 0;
      av(1'h1, `FHC_ADDR_IDX, 32'(a));
      av(1'h1, `FHC_CMD_IDX, c);
      do begin
         av(1'h0, `FHC_STATUS_IDX, 32'h0);
         n++;
      end while (rdat[`FHC_ST_BUSY] !== 1'b0 && n < 100);
      st = rdat;
      av(1'h1, `FHC_STATUS_IDX, 32'h1a);
      av(1'h0, `FHC_RDATA_IDX, 32'h0);
   endtask
   // arm then program one word
   task automatic prog(input logic [21:0] a, input logic [15:0] d);
      av(1'h1, `FHC_WDATA_IDX, 32'h00a0);
      op(a, 32'h2);
      av(1'h1, `FHC_WDATA_IDX, 32'(d));
      op(a, 32'h2);
   endtask
   // closing report
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      `CHK({wait_r, ce_n, oe_n, we_n, dq_oe}, 20'hf0000)
      `CHK({prot_n, spd, rst_n}, 3'h5)
      resetn <= 1'b1;
      @(posedge clk);
      foreach (rows[i]) begin
         av(1'h1, `FHC_CTRL_IDX, 32'(rows[i].c));
         op(rows[i].a, 32'h1);
         `CHK(rdat[15:0], rows[i].e)
         `CHK({prot_n, spd}, {~rows[i].c[1], rows[i].c[2]})
      end
      av(1'h1, `FHC_CTRL_IDX, 32'h0);
      prog(22'h000005, 16'h1234);
      op(22'h100002, 32'h1);
      `CHK(rdat[15:0], 16'ha512)
      `CHK(st[`FHC_ST_READY], 1'b0)
      op(22'h000005, 32'h1);
      `CHK(rdat[7], 1'b1)
      op(22'h000005, 32'h4);
      `CHK(st[`FHC_ST_TMO:`FHC_ST_DONE], 3'h4)
      op(22'h000005, 32'h8);
      op(22'h000005, 32'h1);
      `CHK(rdat[15:0], 16'h1234)
      `CHK(st[`FHC_ST_READY], 1'b1)
      av(1'h1, `FHC_CTRL_IDX, 32'h4);
      prog(22'h000006, 16'h00ff);
      op(22'h000006, 32'h4);
      `CHK(st[`FHC_ST_TMO:`FHC_ST_DONE], 3'h3)
      op(22'h000006, 32'h1);
      `CHK(rdat[15:0], 16'h00ff)
      av(1'h1, `FHC_CTRL_IDX, 32'h2);
      prog(22'h000007, 16'h5a5a);
      op(22'h000007, 32'h1);
      `CHK(rdat[15:0], 16'ha507)
      `CHK({ce_n, dq_oe}, 17'h10000)
      // second command while the first still runs is dropped
      av(1'h1, `FHC_CMD_IDX, 32'h1);
      av(1'h1, `FHC_CMD_IDX, 32'h1);
      op(22'h000007, 32'h1);
      `CHK(st[`FHC_ST_DROP], 1'b1)
      av(1'h0, `FHC_CMD_IDX, 32'h0);
      `CHK(rdat, 32'h0)
      av(1'h0, 3'h7, 32'h0);
      `CHK(rdat, 32'h0)
      print_verdict();
   end
endmodule
`default_nettype wire
